// [watch_corr_defs.svh]
// constants for the watch error correction block
`ifndef WATCH_CORR_DEFS_SVH
`define WATCH_CORR_DEFS_SVH
// register index, the byte address derived from it, and the status byte address
`define WATCH_CORR_INDEX 22'h0f_ff99
`define WATCH_CORR_ADDR (`WATCH_CORR_INDEX << 2)
`define WATCH_STATUS_ADDR 22'h3f_fe80
`define WATCH_ADDR_W 22
// correction register layout and reset value
`define WATCH_CORR_RESET 8'h00
`define WATCH_CORR_SEL_BIT 7
`define WATCH_CORR_SIGN_BIT 6
`define WATCH_CORR_MAG_MSB 5
// sub-second reference rollover count
`define SUBSEC_REF_COUNT 16'h7fff
`define SUBSEC_W 16
// seconds values that select a corrected second, and the last bcd seconds digits, bcd
`define SEC_MARK_00 8'h00
`define SEC_MARK_20 8'h20
`define SEC_MARK_40 8'h40
`define SEC_LAST_LOW 4'h9
`define SEC_LAST_HIGH 4'h5
// axi response codes
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

// [watch_corr_pkg.sv]
// types shared by the watch error correction block
package watch_corr_pkg;
   // fields of the correction register
   typedef struct packed {
      logic interval_select;
      logic sign;
      logic [5:0] magnitude;
   } corr_fields_s;
   // result of the rollover computation
   typedef struct packed {
      logic corrected;
      logic [15:0] limit;
   } rollover_s;
endpackage

// [rtc_rollover_calc.sv]
// rollover count for the current second from the correction setting
`timescale 1ns/1ps
`include "watch_corr_defs.svh"
module rtc_rollover_calc (
   // correction setting and current second
   input wire watch_corr_pkg::corr_fields_s fields,
   input wire logic [7:0] seconds_value,
   // resulting rollover count
   output watch_corr_pkg::rollover_s result
);
   logic marked;
   logic active;
   logic [5:0] steps;
   logic [15:0] delta;

   // choose whether this second is one selected for correction
   always_comb begin
      if (fields.interval_select) begin
         marked = (seconds_value == `SEC_MARK_00);
      end else begin
         marked = (seconds_value == `SEC_MARK_00) || (seconds_value == `SEC_MARK_20)
                  || (seconds_value == `SEC_MARK_40);
      end
      // magnitude bits five to one all zero means no correction
      active = marked && (fields.magnitude[5:1] != 5'h00);
   end

   // signed adjustment in steps of two; range 2..124 either way
   always_comb begin
      if (fields.sign) begin
         steps = 6'(~fields.magnitude + 6'h01);
      end else begin
         steps = 6'(fields.magnitude - 6'h01);
      end
      delta = {9'h000, steps, 1'b0};
      result.corrected = active;
      if (!active) begin
         result.limit = `SUBSEC_REF_COUNT;
      end else if (fields.sign) begin
         result.limit = 16'(`SUBSEC_REF_COUNT - delta);
      end else begin
         result.limit = 16'(`SUBSEC_REF_COUNT + delta);
      end
   end
endmodule

// [rtc_watch_error_correction.sv]
// watch error correction: sub-second and seconds counting with axi4-lite registers
// Summary of operation
// - uncorrected, sub-second counter rolls into seconds at reference count 7FFFH.
// - any reset clears the correction register to 00H.
// - correction register is accessed only as a whole 8-bit unit.
// - interval select 0 corrects at seconds 00, 20 and 40.
// - interval select 1 corrects only at second 00.
// - sign 0 lengthens the second by (magnitude minus one) times two.
// - sign 1 shortens the second by (inverted magnitude plus one) times two.
// - magnitude bits five to one all zero means no correction at all.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "watch_corr_defs.svh"
module rtc_watch_error_correction (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // counting source, one pulse per sub-second count
   input wire logic count_tick,
   // counter outputs
   output logic [7:0] seconds_value,
   output logic second_tick,
   // axi4-lite write address and data
   input wire logic [21:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [21:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // registered state, each with its next value, plus the combinational rollover result and do_write
   watch_corr_pkg::corr_fields_s watch_correction_reg, watch_correction_next;
   watch_corr_pkg::rollover_s rollover;
   logic [15:0] subsecond_counter_reg, subsecond_counter_next;
   logic [7:0] seconds_counter_reg, seconds_counter_next;
   logic second_tick_reg, second_tick_next;
   logic aw_full_reg, aw_full_next;
   logic w_full_reg, w_full_next;
   logic [21:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic do_write;

   // rollover count for the second now in progress
   rtc_rollover_calc calc (
      .fields(watch_correction_reg),
      .seconds_value(seconds_counter_reg),
      .result(rollover)
   );

   // write channels taken independently, committed once both are held
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready = !w_full_reg && !bvalid_reg;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   // read answer and counter outputs come straight from flip-flops
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign seconds_value = seconds_counter_reg;
   assign second_tick = second_tick_reg;

   // write path and the correction register
   always_comb begin
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      watch_correction_next = watch_correction_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      // bvalid holds off the next pair, so a commit never meets a clear
      if (do_write) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         if (aw_addr_reg == `WATCH_CORR_ADDR) begin
            bresp_next = `AXI_RESP_OKAY;
            // only the whole low byte lane updates; other lanes are ignored
            if (w_strb_reg[0]) begin
               watch_correction_next = w_data_reg[7:0];
            end
         end else if (aw_addr_reg == `WATCH_STATUS_ADDR) begin
            bresp_next = `AXI_RESP_OKAY; // status is read-only, write dropped
         end else begin
            bresp_next = `AXI_RESP_SLVERR;
         end
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   // write state; reset loads the correction register with its cleared value
   always_ff @(posedge core_clk) begin
      if (reset) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 22'h00_0000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `AXI_RESP_OKAY;
         watch_correction_reg <= `WATCH_CORR_RESET;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         watch_correction_reg <= watch_correction_next;
      end
   end

   // read path; unmapped addresses answer slverr with zero data
   always_comb begin
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      // a new read is taken only once the previous answer has gone
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = `AXI_RESP_OKAY;
         if (s_axi_araddr == `WATCH_CORR_ADDR) begin
            rdata_next = {24'h00_0000, watch_correction_reg};
         end else if (s_axi_araddr == `WATCH_STATUS_ADDR) begin
            // corrected flag, bcd seconds, sub-second count
            rdata_next = {7'h00, rollover.corrected, seconds_counter_reg,
                          subsecond_counter_reg};
         end else begin
            rdata_next = 32'h0000_0000;
            rresp_next = `AXI_RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // read answer registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= `AXI_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else begin
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   // sub-second and bcd seconds counting; limit is re-read every count,
   // so a write during a correction second would corrupt it
   always_comb begin
      subsecond_counter_next = subsecond_counter_reg;
      seconds_counter_next = seconds_counter_reg;
      second_tick_next = 1'b0;
      if (count_tick) begin
         // >= rather than == so a shortened limit below the count still wraps
         if (subsecond_counter_reg >= rollover.limit) begin
            subsecond_counter_next = 16'h0000;
            second_tick_next = 1'b1;
            // bcd carry: units wrap after 9, tens after 5
            if (seconds_counter_reg[3:0] != `SEC_LAST_LOW) begin
               seconds_counter_next = 8'(seconds_counter_reg + 8'h01);
            end else if (seconds_counter_reg[7:4] != `SEC_LAST_HIGH) begin
               seconds_counter_next = {4'(seconds_counter_reg[7:4] + 4'h1), 4'h0};
            end else begin
               seconds_counter_next = `SEC_MARK_00;
            end
         end else begin
            subsecond_counter_next = 16'(subsecond_counter_reg + 16'h0001);
         end
      end
   end

   // counters; second_tick is registered at the same edge as the wrap
   always_ff @(posedge core_clk) begin
      if (reset) begin
         subsecond_counter_reg <= 16'h0000;
         seconds_counter_reg <= 8'h00;
         second_tick_reg <= 1'b0;
      end else begin
         subsecond_counter_reg <= subsecond_counter_next;
         seconds_counter_reg <= seconds_counter_next;
         second_tick_reg <= second_tick_next;
      end
   end
endmodule

// [rtc_watch_error_correction_assertions.sv]
// port checker for the watch error correction block
`timescale 1ns/1ps
module rtc_watch_error_correction_assertions (
   // clock, reset and counting
   input wire logic core_clk,
   input wire logic reset,
   input wire logic count_tick,
   input wire logic [7:0] seconds_value,
   input wire logic second_tick,
   // register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // both halves taken at one edge: commit in the next cycle, response in the one after
   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   // first cycle after reset must show a cleared counter and idle bus
   property p_rst_clear;
      $fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid && seconds_value == 8'h00;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("state not cleared");
   property p_tick_cause;
      $rose(second_tick) |-> $past(count_tick);
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("second without count");
   // seconds only move together with the wrap pulse
   property p_sec_step;
      $changed(seconds_value) |-> second_tick;
   endproperty
   a_sec_step: assert property (p_sec_step) else $error("seconds moved without a wrap");
   // seconds never run short of 32644 counts, so the pulse is always single
   property p_tick_pulse;
      second_tick |=> !second_tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("second pulse too long");
   property p_bcd;
      seconds_value[3:0] <= 4'h9 && seconds_value[7:4] <= 4'h5;
   endproperty
   a_bcd: assert property (p_bcd) else $error("seconds out of range");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_second: cover property ($rose(second_tick));
endmodule

bind rtc_watch_error_correction rtc_watch_error_correction_assertions i_chk (.core_clk, .reset,
   .count_tick, .seconds_value, .second_tick, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// [tb_rtc_watch_error_correction.sv]
// testbench for the watch error correction block
`timescale 1ns/1ps
`include "watch_corr_defs.svh"
module tb_rtc_watch_error_correction;
   logic core_clk, reset, count_tick, second_tick;
   logic [7:0] seconds_value;
   logic [21:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat, n;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   // settings whose magnitude bits five to one are clear
   logic [7:0] no_corr [3] = '{8'h41, 8'hc1, 8'h01};
   rtc_watch_error_correction i_dut (.core_clk, .reset, .count_tick, .seconds_value, .second_tick,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e);
      check_count++;
      if (resp !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, resp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // readys are combinational, so they are sampled mid-cycle where they have settled
   task automatic wr(input logic [21:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw, w, hs;
      aw = 1'b1;
      w = 1'b1;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge core_clk);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         hs = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge core_clk);
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end while (!hs);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [21:0] a);
      logic tk, hs;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge core_clk);
         tk = s_axi_arready;
         hs = s_axi_rvalid;
         rdat = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge core_clk);
         s_axi_arvalid <= s_axi_arvalid && !tk;
      end while (!hs);
      s_axi_rready <= 1'b0;
   endtask
   // status upper half holds the corrected flag and the seconds
   task automatic st(input logic [15:0] e);
      rd(`WATCH_STATUS_ADDR);
      chk("status", {16'h0000, e}, {16'h0000, rdat[31:16]});
   endtask
   // counts ticks of one second with the counter fed every cycle
   task automatic meas;
      @(posedge core_clk);
      count_tick <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         @(negedge core_clk);
      end while (second_tick !== 1'b1);
      @(posedge core_clk);
      count_tick <= 1'b0;
   endtask
   // hang guard, about three eighths above the two measured seconds
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         results;
      end
   end
   initial begin
      {reset, count_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 5'h1_0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} <= 46'h0000_0000_0000;
      {s_axi_wdata, s_axi_wstrb} <= 36'h0_0000_0000;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      rd(`WATCH_CORR_ADDR);
      chk("corr after reset", 32'h0000_0000, rdat);
      st(16'h0000);
      rd(22'h00_0010);
      chk_resp("unmapped", `AXI_RESP_SLVERR);
      // magnitude bits five to one clear: no correction whatever the sign
      foreach (no_corr[i]) begin
         wr(`WATCH_CORR_ADDR, {24'h00_0000, no_corr[i]}, 4'h1);
         st(16'h0000);
      end
      // largest lengthening on the 20-second interval; counter stopped, no second runs
      wr(`WATCH_CORR_ADDR, 32'hffff_ff3f, 4'h1);
      wr(`WATCH_CORR_ADDR, 32'h0000_0000, 4'h0);
      chk_resp("masked write", `AXI_RESP_OKAY);
      rd(`WATCH_CORR_ADDR);
      chk("corr byte", 32'h0000_003f, rdat);
      st(16'h0100);
      meas;
      chk("long second", 32'h0000_8000 + 2 * (63 - 1), n);
      chk("seconds port", 32'h0000_0001, {24'h00_0000, seconds_value});
      st(16'h0001);
      // second 01 is outside every correction second, so the write is allowed
      wr(`WATCH_CORR_ADDR, 32'h0000_00bf, 4'h1);
      st(16'h0001);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rd(`WATCH_CORR_ADDR);
      chk("corr after reset", 32'h0000_0000, rdat);
      wr(`WATCH_CORR_ADDR, 32'h0000_00c2, 4'h1);
      st(16'h0100);
      meas;
      chk("short second", 32'h0000_8000 - 2 * (6'h3d + 1), n);
      results;
   end
endmodule
